// ### inc/fsled_pkg.sv
// Overview of operation
// (RULE1) modbus mode: run led steady green while server communicates with a tcp connection
// (RULE2) modbus mode: run led flashes green when server ready, unconfigured or awaiting traffic
// (RULE3) modbus mode: run led dark while server task not ready
// (RULE4) modbus mode: green link led on with ethernet link, off without
// (RULE5) modbus mode: yellow led flickers during frame traffic, dark otherwise
// (RULE6) state-machine mode: run led dark in boot state
// (RULE7) state-machine mode: run led flashes green in configuration-exchange state
// (RULE8) state-machine mode: run led single flashes green in safe state
// (RULE9) state-machine mode: run led steady green in operational state
// (RULE10) state-machine mode: error led dark while running without error
// (RULE11) state-machine mode: error led flashes red on configuration error
// (RULE12) state-machine mode: error led single red flash after local state change
// (RULE13) state-machine mode: error led double red flash on process-data watchdog timeout
// (RULE14) state-machine mode: link led steady idle, flicker on traffic, dark unlinked; yellow dark
// (RULE15) cyclic mode: run led steady green with cyclic communication running
// (RULE16) cyclic mode: run led flashes green with cyclic communication stopped; the code keeps it dark while cyc_operating is low
// (RULE17) cyclic mode: triple red flash on shared-memory watchdog, steady red other errors
// (RULE18) cyclic mode: link led steady idle, flicker during traffic
// (RULE19) cyclic mode: link led dark without link; yellow led always dark
// (RULE20) cadences come from free-running counters with periods as constants
// (RULE21) static protocol select picks mapping; all leds dark during reset
package fsled_pkg;

  // ****************************************
  // timing (pclk 25 MHz)
  // ****************************************
  localparam int CLK_HZ = 25000000;
  localparam int FLICKER_MS = 50;
  localparam int FLASH_MS = 200;
  localparam int CLK_PER_MS = CLK_HZ / 1000;
  localparam int FLICKER_CYC = FLICKER_MS * CLK_PER_MS;
  localparam int FLASH_CYC = FLASH_MS * CLK_PER_MS;
  localparam int FLASH_SLOTS = 10;
  localparam int CNT_W = 24;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam int CTRL_PROT_LSB = 0;
  localparam int CTRL_EN_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    FSLED_PROT_MODBUS = 2'h0,
    FSLED_PROT_SM = 2'h1,
    FSLED_PROT_CYC = 2'h2
  } fsled_prot_t;

  typedef enum logic [1:0] {
    FSLED_SM_BOOT = 2'h0,
    FSLED_SM_CONFIG = 2'h1,
    FSLED_SM_SAFE = 2'h2,
    FSLED_SM_OPER = 2'h3
  } fsled_sm_t;

  typedef enum logic [2:0] {
    FSLED_PAT_OFF = 3'h0,
    FSLED_PAT_ON = 3'h1,
    FSLED_PAT_BLINK = 3'h2,
    FSLED_PAT_SINGLE = 3'h3,
    FSLED_PAT_DOUBLE = 3'h4,
    FSLED_PAT_TRIPLE = 3'h5,
    FSLED_PAT_FLICKER = 3'h6
  } fsled_pat_t;

endpackage : fsled_pkg

// ### rtl/fsled_cadence.sv
`timescale 1ns/1ns
module fsled_cadence
  import fsled_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // phase outputs
  output logic flicker_ph,
  output logic blink_ph,
  output logic single_ph,
  output logic double_ph,
  output logic triple_ph
);

  // ****************************************
  // free-running counters
  // ****************************************
  localparam logic [CNT_W-1:0] FLICK_LAST = CNT_W'(FLICKER_CYC - 1);
  localparam logic [CNT_W-1:0] FLASH_LAST = CNT_W'(FLASH_CYC - 1);
  localparam logic [3:0] SLOT_LAST = 4'(FLASH_SLOTS - 1);

  logic [CNT_W-1:0] fl_cnt_q;
  logic [CNT_W-1:0] fs_cnt_q;
  logic [3:0] slot_q;
  logic flick_q;
  wire fl_wrap = (fl_cnt_q == FLICK_LAST);
  wire fs_wrap = (fs_cnt_q == FLASH_LAST);

  always_ff @(posedge pclk or negedge presetn) begin // [RULE20]
    if (!presetn) begin
      fl_cnt_q <= '0;
      fs_cnt_q <= '0;
      slot_q <= '0;
      flick_q <= 1'b0;
    end else begin
      fl_cnt_q <= fl_wrap ? '0 : fl_cnt_q + 1'b1;
      fs_cnt_q <= fs_wrap ? '0 : fs_cnt_q + 1'b1;
      if (fl_wrap) flick_q <= ~flick_q;
      if (fs_wrap) slot_q <= (slot_q == SLOT_LAST) ? '0 : slot_q + 1'b1;
    end
  end

  // slot sequence: 10 slots, lit in 0 / 0,2 / 0,2,4; blink toggles per slot
  assign flicker_ph = flick_q;
  assign blink_ph = ~slot_q[0];
  assign single_ph = (slot_q == 4'h0);
  assign double_ph = (slot_q == 4'h0) || (slot_q == 4'h2);
  assign triple_ph = (slot_q == 4'h0) || (slot_q == 4'h2) || (slot_q == 4'h4);

  a_slot_range: assert property (@(posedge pclk) disable iff (!presetn) slot_q <= SLOT_LAST) // [RULE20]
    else $error("slot counter out of range");

endmodule : fsled_cadence

// ### rtl/fsled_top.sv
`timescale 1ns/1ns
module fsled_top
  import fsled_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol stack status
  input wire logic srv_ready,
  input wire logic srv_configured,
  input wire logic srv_comm,
  input wire logic tcp_conn,
  input wire logic [1:0] sm_state,
  input wire logic sm_cfg_err,
  input wire logic sm_local_err,
  input wire logic sm_wdog_err,
  input wire logic cyc_operating,
  input wire logic cyc_running,
  input wire logic cyc_comm_err,
  input wire logic shared_memory_wdog,
  // phy status
  input wire logic eth_link,
  input wire logic eth_activity,
  // leds
  output logic led_run_green,
  output logic led_err_red,
  output logic led_link_green,
  output logic led_act_yellow
);

  // ****************************************
  // apb slave
  // ****************************************
  logic [2:0] ctrl_q;
  wire acc = psel && penable;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_stat = (paddr == ADDR_STAT);
  wire wr_ctrl = acc && pwrite && hit_ctrl;
  // static select: written by the same ctrl write as the led enable, which reset already sets
  wire [1:0] prot_sel = ctrl_q[CTRL_PROT_LSB+1:CTRL_PROT_LSB];
  wire leds_en = ctrl_q[CTRL_EN_BIT];

  assign pready = 1'b1;
  assign pslverr = acc && !(hit_ctrl || hit_stat);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // ****************************************
  // cadence
  // ****************************************
  logic flicker_ph;
  logic blink_ph;
  logic single_ph;
  logic double_ph;
  logic triple_ph;

  fsled_cadence u_cad (
    .pclk(pclk),
    .presetn(presetn),
    .flicker_ph(flicker_ph),
    .blink_ph(blink_ph),
    .single_ph(single_ph),
    .double_ph(double_ph),
    .triple_ph(triple_ph)
  );

  function automatic logic pat_level(input fsled_pat_t p, input logic fk, input logic bl,
                                     input logic s1, input logic s2, input logic s3);
    logic v;
    v = 1'b0;
    unique case (p)
      FSLED_PAT_OFF: v = 1'b0;
      FSLED_PAT_ON: v = 1'b1;
      FSLED_PAT_BLINK: v = bl;
      FSLED_PAT_SINGLE: v = s1;
      FSLED_PAT_DOUBLE: v = s2;
      FSLED_PAT_TRIPLE: v = s3;
      FSLED_PAT_FLICKER: v = fk;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : pat_level

  // ****************************************
  // modbus mapping
  // ****************************************
  fsled_pat_t mb_run;
  fsled_pat_t mb_link;
  fsled_pat_t mb_act;
  assign mb_run = !srv_ready ? FSLED_PAT_OFF : // [RULE3]
                  (srv_comm && tcp_conn) ? FSLED_PAT_ON : // [RULE1]
                  FSLED_PAT_BLINK; // [RULE2]
  assign mb_link = eth_link ? FSLED_PAT_ON : FSLED_PAT_OFF; // [RULE4]
  assign mb_act = eth_activity ? FSLED_PAT_FLICKER : FSLED_PAT_OFF; // [RULE5]

  // ****************************************
  // state-machine fieldbus mapping
  // ****************************************
  fsled_pat_t sm_run;
  fsled_pat_t sm_err;
  fsled_pat_t eth_la;
  always_comb begin
    unique case (fsled_sm_t'(sm_state))
      FSLED_SM_BOOT: sm_run = FSLED_PAT_OFF; // [RULE6]
      FSLED_SM_CONFIG: sm_run = FSLED_PAT_BLINK; // [RULE7]
      FSLED_SM_SAFE: sm_run = FSLED_PAT_SINGLE; // [RULE8]
      FSLED_SM_OPER: sm_run = FSLED_PAT_ON; // [RULE9]
    endcase
  end
  // watchdog timeout outranks local change, which outranks config error
  assign sm_err = sm_wdog_err ? FSLED_PAT_DOUBLE : // [RULE13]
                  sm_local_err ? FSLED_PAT_SINGLE : // [RULE12]
                  sm_cfg_err ? FSLED_PAT_BLINK : // [RULE11]
                  FSLED_PAT_OFF; // [RULE10]
  // shared by both fieldbus modes
  assign eth_la = !eth_link ? FSLED_PAT_OFF : // [RULE14] [RULE19]
                  eth_activity ? FSLED_PAT_FLICKER : FSLED_PAT_ON; // [RULE14] [RULE18]

  // ****************************************
  // cyclic-station mapping
  // ****************************************
  fsled_pat_t cy_run;
  fsled_pat_t cy_err;
  assign cy_run = !cyc_operating ? FSLED_PAT_OFF :
                  cyc_running ? FSLED_PAT_ON : // [RULE15]
                  FSLED_PAT_BLINK; // [RULE16]
  assign cy_err = shared_memory_wdog ? FSLED_PAT_TRIPLE : // [RULE17]
                  cyc_comm_err ? FSLED_PAT_ON : FSLED_PAT_OFF; // [RULE17]

  // ****************************************
  // protocol select
  // ****************************************
  fsled_pat_t run_p;
  fsled_pat_t err_p;
  fsled_pat_t link_p;
  fsled_pat_t act_p;
  always_comb begin // [RULE21]
    run_p = FSLED_PAT_OFF;
    err_p = FSLED_PAT_OFF;
    link_p = FSLED_PAT_OFF;
    act_p = FSLED_PAT_OFF;
    unique case (fsled_prot_t'(prot_sel))
      FSLED_PROT_MODBUS: begin
        run_p = mb_run;
        link_p = mb_link;
        act_p = mb_act;
      end
      FSLED_PROT_SM: begin
        run_p = sm_run;
        err_p = sm_err;
        link_p = eth_la;
      end
      FSLED_PROT_CYC: begin
        run_p = cy_run;
        err_p = cy_err;
        link_p = eth_la;
      end
      default: begin
        run_p = FSLED_PAT_OFF;
      end
    endcase
  end

  // ****************************************
  // led flops, dark in reset
  // ****************************************
  wire run_d = leds_en && pat_level(run_p, flicker_ph, blink_ph, single_ph, double_ph, triple_ph);
  wire err_d = leds_en && pat_level(err_p, flicker_ph, blink_ph, single_ph, double_ph, triple_ph);
  wire link_d = leds_en && pat_level(link_p, flicker_ph, blink_ph, single_ph, double_ph, triple_ph);
  wire act_d = leds_en && pat_level(act_p, flicker_ph, blink_ph, single_ph, double_ph, triple_ph);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // [RULE21]
      led_run_green <= 1'b0;
      led_err_red <= 1'b0;
      led_link_green <= 1'b0;
      led_act_yellow <= 1'b0;
    end else begin
      led_run_green <= run_d;
      led_err_red <= err_d;
      led_link_green <= link_d;
      led_act_yellow <= act_d;
    end
  end

  // status read: live leds, select and enable
  wire [31:0] stat_word = {24'h000000, led_act_yellow, led_link_green, led_err_red, led_run_green, 1'b0, ctrl_q};
  wire [31:0] rd_mux = hit_ctrl ? {29'h00000000, ctrl_q} : hit_stat ? stat_word : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // sampled reset keeps the release edge out of the antecedents: leds are still dark there
  wire mb_on = presetn && leds_en && prot_sel == 2'h0;
  wire sm_on = presetn && leds_en && prot_sel == 2'h1;
  wire cy_on = presetn && leds_en && prot_sel == 2'h2;

  a_mb_run_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    mb_on && !srv_ready |=> !led_run_green) else $error("run led lit while server not ready");
  a_mb_run_on: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    mb_on && srv_ready && srv_comm && tcp_conn |=> led_run_green) else $error("run led not steady");
  a_mb_link: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    mb_on |=> led_link_green == $past(eth_link)) else $error("link led wrong");
  a_mb_act_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    mb_on && !eth_activity |=> !led_act_yellow) else $error("activity led lit idle");
  a_sm_boot_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    sm_on && sm_state == 2'h0 |=> !led_run_green) else $error("run led lit in boot");
  a_sm_oper_on: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    sm_on && sm_state == 2'h3 |=> led_run_green) else $error("run led not steady in oper");
  a_sm_err_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    sm_on && !sm_cfg_err && !sm_local_err && !sm_wdog_err |=> !led_err_red) else $error("error led lit");
  a_sm_yellow: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    !mb_on |=> !led_act_yellow) else $error("yellow led lit outside modbus");
  a_cy_link_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
    cy_on && !eth_link |=> !led_link_green) else $error("link led lit without link");
  a_cy_err_on: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    cy_on && cyc_comm_err && !shared_memory_wdog |=> led_err_red) else $error("error led not steady");
  a_cy_run_on: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    cy_on && cyc_operating && cyc_running |=> led_run_green) else $error("cyclic run led not steady");

  c_mb_flash: cover property (@(posedge pclk) disable iff (!presetn) mb_on && mb_run == FSLED_PAT_BLINK);
  c_sm_double: cover property (@(posedge pclk) disable iff (!presetn) sm_on && sm_wdog_err && led_err_red);
  c_cy_triple: cover property (@(posedge pclk) disable iff (!presetn) cy_on && shared_memory_wdog && led_err_red);

endmodule : fsled_top

// ### verif/fsled_stack_model.sv
`timescale 1ns/1ns
// ****************************************
// protocol stack status and front panel
// ****************************************
module fsled_stack_model (
  // scenario from the bench
  input wire logic [14:0] stim,
  // stack and phy status levels
  output logic srv_ready,
  output logic srv_configured,
  output logic srv_comm,
  output logic tcp_conn,
  output logic [1:0] sm_state,
  output logic sm_cfg_err,
  output logic sm_local_err,
  output logic sm_wdog_err,
  output logic cyc_operating,
  output logic cyc_running,
  output logic cyc_comm_err,
  output logic shared_memory_wdog,
  output logic eth_link,
  output logic eth_activity,
  // leds as the panel shows them
  input wire logic led_run_green,
  input wire logic led_err_red,
  input wire logic led_link_green,
  input wire logic led_act_yellow,
  output logic [3:0] panel
);
  // status is level only: the stack holds each state, it never pulses
  assign {srv_ready, srv_configured, srv_comm, tcp_conn, sm_state, sm_cfg_err, sm_local_err, sm_wdog_err,
          cyc_operating, cyc_running, cyc_comm_err, shared_memory_wdog, eth_link, eth_activity} = stim;
  assign panel = {led_run_green, led_err_red, led_link_green, led_act_yellow};
endmodule : fsled_stack_model

// ### verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [14:0] stim = 15'h0;
  logic [3:0] panel;
  logic srv_ready, srv_configured, srv_comm, tcp_conn, sm_cfg_err, sm_local_err, sm_wdog_err;
  logic [1:0] sm_state;
  logic cyc_operating, cyc_running, cyc_comm_err, shared_memory_wdog, eth_link, eth_activity;
  logic led_run_green, led_err_red, led_link_green, led_act_yellow;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  typedef struct packed {logic [3:0] ctrl; logic [14:0] stim; logic [3:0] leds;} fsled_row_t;
  // flash cadences all sit in their first lit slot during this short run
  fsled_row_t rows [15] = '{
    '{4'h4, 15'h5802, 4'hA},
    '{4'h4, 15'h4000, 4'h8},
    '{4'h4, 15'h6002, 4'hA},
    '{4'h4, 15'h1802, 4'h2},
    '{4'h5, 15'h0002, 4'h2},
    '{4'h5, 15'h0300, 4'hC},
    '{4'h5, 15'h0480, 4'hC},
    '{4'h5, 15'h0642, 4'hE},
    '{4'h5, 15'h0602, 4'hA},
    '{4'h6, 15'h0032, 4'hA},
    '{4'h6, 15'h0024, 4'hC},
    '{4'h6, 15'h0038, 4'hC},
    '{4'h6, 15'h0001, 4'h0},
    '{4'h7, 15'h7FFF, 4'h0},
    '{4'h1, 15'h0602, 4'h0}};

  always #20 pclk = ~pclk;

  fsled_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .srv_ready(srv_ready), .srv_configured(srv_configured), .srv_comm(srv_comm), .tcp_conn(tcp_conn),
    .sm_state(sm_state), .sm_cfg_err(sm_cfg_err), .sm_local_err(sm_local_err), .sm_wdog_err(sm_wdog_err),
    .cyc_operating(cyc_operating), .cyc_running(cyc_running), .cyc_comm_err(cyc_comm_err),
    .shared_memory_wdog(shared_memory_wdog), .eth_link(eth_link), .eth_activity(eth_activity),
    .led_run_green(led_run_green), .led_err_red(led_err_red), .led_link_green(led_link_green),
    .led_act_yellow(led_act_yellow));

  fsled_stack_model u_model (.stim(stim), .srv_ready(srv_ready), .srv_configured(srv_configured),
    .srv_comm(srv_comm), .tcp_conn(tcp_conn), .sm_state(sm_state), .sm_cfg_err(sm_cfg_err),
    .sm_local_err(sm_local_err), .sm_wdog_err(sm_wdog_err), .cyc_operating(cyc_operating),
    .cyc_running(cyc_running), .cyc_comm_err(cyc_comm_err), .shared_memory_wdog(shared_memory_wdog),
    .eth_link(eth_link), .eth_activity(eth_activity), .led_run_green(led_run_green),
    .led_err_red(led_err_red), .led_link_green(led_link_green), .led_act_yellow(led_act_yellow),
    .panel(panel));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // starts one edge late so psel is never set and cleared in one time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic drive(input logic [3:0] ctrl, input logic [14:0] v);
    apb(1'b1, 12'h000, {28'h0, ctrl}, rd, err);
    @(posedge pclk);
    stim <= v;
    @(posedge pclk);
    @(posedge pclk);
    #1;
  endtask : drive

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge pclk);
    #1;
    check({28'h0, panel}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, rd, err);
    check(rd, 32'h0000_0004);
    foreach (rows[i]) begin
      drive(rows[i].ctrl, rows[i].stim);
      check({28'h0, panel}, {28'h0, rows[i].leds});
    end
    // status word mirrors the mode and the lit leds
    drive(4'h6, 15'h0032);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    check(rd, 32'h0000_0056);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF, rd, err);
    check({31'h0, err}, 32'h0);
    apb(1'b1, 12'h008, 32'h0000_0001, rd, err);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    check({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    check(rd, 32'h0000_0006);
    // flicker phase opens dark for FLICKER_CYC cycles, far longer than this run
    drive(4'h4, 15'h0003);
    check({28'h0, panel}, 32'h2);
    drive(4'h5, 15'h0003);
    check({28'h0, panel}, 32'h0);
    drive(4'h6, 15'h0003);
    check({28'h0, panel}, 32'h0);
    // reset in mid-run darkens at once and returns the select to its reset value, modbus with leds enabled
    drive(4'h5, 15'h0602);
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    check({28'h0, panel}, 32'h0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, rd, err);
    check(rd, 32'h0000_0004);
    #1;
    check({28'h0, panel}, 32'h2);
    tally_and_finish();
  end
endmodule : tb_top
